//--- rtl/lldp_port.sv
`timescale 1ns/1ps
module lldp_port #(
  parameter int ROW_W = 8
) (
  input wire logic clk, // Core clock
  input wire logic rst_n, // Reset, active low
  input wire logic commandClockTrue, // Command clock, rising edge used
  input wire logic selectN, // Chip select, active low
  input wire logic writeEnableN, // Write enable, active low
  input wire logic refreshN, // Refresh strobe, active low
  input wire logic [lldp_pkg::BANK_W-1:0] bank, // Bank address
  input wire logic [lldp_pkg::ADDR_W-1:0] addr, // Word address
  input wire logic writeDataClock, // Write data clock
  input wire logic [lldp_pkg::DATA_W-1:0] dataIn, // Data pins, input side
  output logic [lldp_pkg::DATA_W-1:0] dataOut, // Data pins, output side
  output logic dataOutEn, // High while driving data pins
  output logic readDataClock, // Free-running read data clock
  output logic readValid, // Read word on the pins
  output logic [1:0] burstCount, // Mode register burst code
  output logic cmdDropped, // Command refused, one cycle
  output logic refreshDone, // Refresh carried out, one core cycle
  output logic [lldp_pkg::BANK_W-1:0] refreshBank, // Bank last refreshed
  output logic [ROW_W-1:0] refreshRow // Row last refreshed
);

  generate
    if (ROW_W < 1 || ROW_W > 16) begin : gBadRow
      $error("lldp_port: ROW_W must lie between 1 and 16");
    end
  endgenerate

  // Link-domain state
  logic linkRstMeta;
  logic linkRst_n;
  logic [lldp_pkg::DATA_W-1:0] riseWord;
  logic [lldp_pkg::DATA_W-1:0] fallWord;
  lldp_pkg::lldp_cmd_t cmdNow;
  logic wantsQueue;
  lldp_pkg::lldp_link_t linkState;
  lldp_pkg::lldp_req_t stage;
  logic [1:0] wrPair;
  logic lastPair;
  logic reqReady;
  logic reqValid;

  // Read return state on the link side
  logic retValid;
  logic retReady;
  lldp_pkg::lldp_ret_t retData;
  logic rdBusy;
  logic [3:0] rdIdx;
  logic [1:0] rdBurst;
  lldp_pkg::lldp_burst_t rdWords;

  // Core-domain state
  lldp_pkg::lldp_core_t coreState;
  lldp_pkg::lldp_req_t cur;
  lldp_pkg::lldp_req_t reqOut;
  logic reqOutValid;
  logic reqOutReady;
  logic [2:0] beat;
  logic lastBeat;
  lldp_pkg::lldp_burst_t retBuf;
  lldp_pkg::lldp_ret_t retIn;
  logic retInValid;
  logic retInReady;
  logic refreshHit;
  logic [lldp_pkg::BANK_W+lldp_pkg::ADDR_W-1:0] memAddr;
  logic [lldp_pkg::DATA_W-1:0] mem [0:lldp_pkg::BANKS*(2**lldp_pkg::ADDR_W)-1];
  logic [ROW_W-1:0] refreshRows [0:lldp_pkg::BANKS-1];

  // Pin levels to command; only ever looked at on a rising command edge
  function automatic lldp_pkg::lldp_cmd_t decodeCmd(input logic selN, input logic weN,
                                                    input logic refN);
    case ({selN, weN, refN})
      3'h0: decodeCmd = lldp_pkg::CMD_MRS;
      3'h1: decodeCmd = lldp_pkg::CMD_WRITE;
      3'h3: decodeCmd = lldp_pkg::CMD_READ;
      3'h2: decodeCmd = lldp_pkg::CMD_AREF;
      default: decodeCmd = lldp_pkg::CMD_NOP;
    endcase
  endfunction

  // Queue kind for a command that needs the core
  function automatic lldp_pkg::lldp_kind_t kindOf(input lldp_pkg::lldp_cmd_t cmd);
    case (cmd)
      lldp_pkg::CMD_READ: kindOf = lldp_pkg::KIND_READ;
      lldp_pkg::CMD_AREF: kindOf = lldp_pkg::KIND_REFRESH;
      default: kindOf = lldp_pkg::KIND_WRITE;
    endcase
  endfunction

  // Reset release retimed to the command clock; assertion stays asynchronous
  always_ff @(posedge commandClockTrue or negedge rst_n) begin
    if (!rst_n) begin
      linkRstMeta <= 1'b0;
      linkRst_n <= 1'b0;
    end else begin
      linkRstMeta <= 1'b1;
      linkRst_n <= linkRstMeta;
    end
  end

  // Rising-edge word; write data clock must run in phase with the command clock
  always_ff @(posedge writeDataClock or negedge linkRst_n) begin
    if (!linkRst_n) begin
      riseWord <= '0;
    end else begin
      riseWord <= dataIn;
    end
  end

  // Falling-edge word, second of each pair
  always_ff @(negedge writeDataClock or negedge linkRst_n) begin
    if (!linkRst_n) begin
      fallWord <= '0;
    end else begin
      fallWord <= dataIn;
    end
  end

  assign cmdNow = decodeCmd(selectN, writeEnableN, refreshN);
  assign wantsQueue = cmdNow == lldp_pkg::CMD_WRITE || cmdNow == lldp_pkg::CMD_READ ||
                      cmdNow == lldp_pkg::CMD_AREF;
  assign lastPair = 3'({wrPair, 1'b1}) == 3'(lldp_pkg::burstWords(stage.burst) - 4'h1);
  assign reqValid = linkState == lldp_pkg::LK_STAGE;

  // Mode register: any time, reserved code ignored so a bad write cannot break bursts
  always_ff @(posedge commandClockTrue or negedge linkRst_n) begin
    if (!linkRst_n) begin
      burstCount <= lldp_pkg::BURST_RESET;
    end else if (cmdNow == lldp_pkg::CMD_MRS &&
                 addr[lldp_pkg::MODE_BURST_LSB +: 2] != lldp_pkg::BURST_CODE_RSVD) begin
      burstCount <= addr[lldp_pkg::MODE_BURST_LSB +: 2];
    end
  end

  // A queued command arriving while the previous one is still in hand is refused
  always_ff @(posedge commandClockTrue or negedge linkRst_n) begin
    if (!linkRst_n) begin
      cmdDropped <= 1'b0;
    end else begin
      cmdDropped <= wantsQueue && linkState != lldp_pkg::LK_IDLE;
    end
  end

  // Link sequencer: take a command, gather write pairs, hand the entry over
  always_ff @(posedge commandClockTrue or negedge linkRst_n) begin
    if (!linkRst_n) begin
      linkState <= lldp_pkg::LK_IDLE;
      stage <= '0;
      wrPair <= 2'h0;
    end else begin
      case (linkState)
        lldp_pkg::LK_IDLE: begin
          if (wantsQueue) begin
            stage.kind <= kindOf(cmdNow);
            stage.bank <= bank;
            // Refresh carries no row; the core picks it
            stage.addr <= (cmdNow == lldp_pkg::CMD_AREF) ? '0 : addr;
            stage.burst <= burstCount;
            stage.data <= '0;
            wrPair <= 2'h0;
            linkState <= (cmdNow == lldp_pkg::CMD_WRITE) ? lldp_pkg::LK_WAIT
                                                        : lldp_pkg::LK_STAGE;
          end
        end
        lldp_pkg::LK_WAIT: begin
          // First pair is still being caught on the write data clock
          linkState <= lldp_pkg::LK_COLLECT;
        end
        lldp_pkg::LK_COLLECT: begin
          stage.data[{wrPair, 1'b0}] <= riseWord;
          stage.data[{wrPair, 1'b1}] <= fallWord;
          wrPair <= wrPair + 2'h1;
          if (lastPair) begin
            linkState <= lldp_pkg::LK_STAGE;
          end
        end
        lldp_pkg::LK_STAGE: begin
          // Full request queue holds the sequencer here
          if (reqReady) begin
            linkState <= lldp_pkg::LK_IDLE;
          end
        end
        default: begin
          linkState <= lldp_pkg::LK_IDLE;
        end
      endcase
    end
  end

  // Requests cross to the core clock through a Gray-pointer queue
  lldp_async_fifo #(
    .WIDTH($bits(lldp_pkg::lldp_req_t)),
    .DEPTH(lldp_pkg::FIFO_DEPTH)
  ) reqFifo (
    .wrClk(commandClockTrue),
    .wrRst_n(linkRst_n),
    .wrValid(reqValid),
    .wrReady(reqReady),
    .wrData(stage),
    .rdClk(clk),
    .rdRst_n(rst_n),
    .rdValid(reqOutValid),
    .rdReady(reqOutReady),
    .rdData(reqOut)
  );

  assign reqOutReady = coreState == lldp_pkg::CORE_IDLE;
  assign refreshHit = reqOutReady && reqOutValid && reqOut.kind == lldp_pkg::KIND_REFRESH;
  assign memAddr = {cur.bank, lldp_pkg::ADDR_W'(cur.addr + lldp_pkg::ADDR_W'(beat))};
  assign lastBeat = 4'({1'b0, beat}) == lldp_pkg::burstWords(cur.burst) - 4'h1;
  assign retInValid = coreState == lldp_pkg::CORE_RET;
  assign retIn = '{burst: cur.burst, data: retBuf};

  // Core sequencer: one word per core clock; the link meanwhile takes the next bank
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      coreState <= lldp_pkg::CORE_IDLE;
      cur <= '0;
      beat <= 3'h0;
      retBuf <= '0;
    end else begin
      case (coreState)
        lldp_pkg::CORE_IDLE: begin
          if (reqOutValid && reqOut.kind != lldp_pkg::KIND_REFRESH) begin
            cur <= reqOut;
            beat <= 3'h0;
            coreState <= lldp_pkg::CORE_RUN;
          end
        end
        lldp_pkg::CORE_RUN: begin
          if (cur.kind == lldp_pkg::KIND_READ) begin
            retBuf[beat] <= mem[memAddr];
          end
          beat <= beat + 3'h1;
          if (lastBeat) begin
            coreState <= (cur.kind == lldp_pkg::KIND_READ) ? lldp_pkg::CORE_RET
                                                           : lldp_pkg::CORE_IDLE;
          end
        end
        lldp_pkg::CORE_RET: begin
          // Stalls while the return queue is full
          if (retInReady) begin
            coreState <= lldp_pkg::CORE_IDLE;
          end
        end
        default: begin
          coreState <= lldp_pkg::CORE_IDLE;
        end
      endcase
    end
  end

  // Array: bank in the top address bits, so banks never alias
  always_ff @(posedge clk) begin
    if (coreState == lldp_pkg::CORE_RUN && cur.kind == lldp_pkg::KIND_WRITE) begin
      mem[memAddr] <= cur.data[beat];
    end
  end

  // One row counter per bank, stepped only by that bank's refresh
  generate
    for (genvar b = 0; b < lldp_pkg::BANKS; b++) begin : gRefresh
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          refreshRows[b] <= lldp_pkg::ROW_RESET[ROW_W-1:0];
        end else if (refreshHit && reqOut.bank == lldp_pkg::BANK_W'(b)) begin
          refreshRows[b] <= refreshRows[b] + 1'b1;
        end
      end
    end
  endgenerate

  // Report which bank and row a refresh touched
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      refreshDone <= 1'b0;
      refreshBank <= '0;
      refreshRow <= '0;
    end else begin
      refreshDone <= refreshHit;
      if (refreshHit) begin
        refreshBank <= reqOut.bank;
        refreshRow <= refreshRows[reqOut.bank];
      end
    end
  end

  // Read bursts cross back to the link clock
  lldp_async_fifo #(
    .WIDTH($bits(lldp_pkg::lldp_ret_t)),
    .DEPTH(lldp_pkg::FIFO_DEPTH)
  ) retFifo (
    .wrClk(clk),
    .wrRst_n(rst_n),
    .wrValid(retInValid),
    .wrReady(retInReady),
    .wrData(retIn),
    .rdClk(commandClockTrue),
    .rdRst_n(linkRst_n),
    .rdValid(retValid),
    .rdReady(retReady),
    .rdData(retData)
  );

  // Half-rate read clock runs always, so the controller can lock to it
  always_ff @(posedge commandClockTrue or negedge linkRst_n) begin
    if (!linkRst_n) begin
      readDataClock <= 1'b0;
    end else begin
      readDataClock <= ~readDataClock;
    end
  end

  // Start only while the read clock is low so word 0 meets its rising edge
  assign retReady = !rdBusy && !readDataClock;

  // Serialiser: one word per command edge, two per read clock cycle
  always_ff @(posedge commandClockTrue or negedge linkRst_n) begin
    if (!linkRst_n) begin
      rdBusy <= 1'b0;
      rdIdx <= 4'h0;
      rdBurst <= lldp_pkg::BURST_RESET;
      rdWords <= '0;
      dataOut <= '0;
      dataOutEn <= 1'b0;
      readValid <= 1'b0;
    end else if (!rdBusy) begin
      if (retValid && retReady) begin
        rdWords <= retData.data;
        rdBurst <= retData.burst;
        rdIdx <= 4'h1;
        rdBusy <= 1'b1;
        dataOut <= retData.data[0];
        dataOutEn <= 1'b1;
        readValid <= 1'b1;
      end else begin
        dataOutEn <= 1'b0;
        readValid <= 1'b0;
      end
    end else if (rdIdx == lldp_pkg::burstWords(rdBurst)) begin
      rdBusy <= 1'b0;
      dataOutEn <= 1'b0;
      readValid <= 1'b0;
    end else begin
      dataOut <= rdWords[rdIdx[2:0]];
      rdIdx <= rdIdx + 4'h1;
    end
  end

endmodule // lldp_port

//--- rtl/lldp_pkg.sv
package lldp_pkg;

  // Data path and array geometry
  localparam int DATA_W = 9;
  localparam int BANKS = 8;
  localparam int BANK_W = 3;
  localparam int ADDR_W = 6;
  localparam int MAX_BURST = 8;
  localparam int FIFO_DEPTH = 8;

  // Burst length codes held in the mode register, taken from the low address bits
  localparam logic [1:0] BURST_CODE_2 = 2'h0;
  localparam logic [1:0] BURST_CODE_4 = 2'h1;
  localparam logic [1:0] BURST_CODE_8 = 2'h2;
  localparam logic [1:0] BURST_CODE_RSVD = 2'h3;
  localparam logic [1:0] BURST_RESET = BURST_CODE_2;
  localparam int MODE_BURST_LSB = 0;

  // Reset values of the core refresh row counters
  localparam logic [15:0] ROW_RESET = 16'h0000;

  // Commands decoded from the select, write-enable and refresh pins
  typedef enum logic [2:0] {
    CMD_NOP = 3'h0,
    CMD_MRS = 3'h1,
    CMD_WRITE = 3'h2,
    CMD_READ = 3'h3,
    CMD_AREF = 3'h4
  } lldp_cmd_t;

  // Kind of work queued towards the core
  typedef enum logic [1:0] {
    KIND_WRITE = 2'h0,
    KIND_READ = 2'h1,
    KIND_REFRESH = 2'h2
  } lldp_kind_t;

  // Link-side sequencer, Gray along idle, wait, collect, stage
  typedef enum logic [1:0] {
    LK_IDLE = 2'h0,
    LK_WAIT = 2'h1,
    LK_COLLECT = 2'h3,
    LK_STAGE = 2'h2
  } lldp_link_t;

  // Core sequencer, Gray along idle, run, return
  typedef enum logic [1:0] {
    CORE_IDLE = 2'h0,
    CORE_RUN = 2'h1,
    CORE_RET = 2'h3
  } lldp_core_t;

  typedef logic [MAX_BURST-1:0][DATA_W-1:0] lldp_burst_t;

  // One queued access: what, where, how long, and write words
  typedef struct packed {
    lldp_kind_t kind;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] addr;
    logic [1:0] burst;
    lldp_burst_t data;
  } lldp_req_t;

  // One returned read burst
  typedef struct packed {
    logic [1:0] burst;
    lldp_burst_t data;
  } lldp_ret_t;

  // Words in a burst for a mode code; reserved code never gets stored
  function automatic logic [3:0] burstWords(input logic [1:0] code);
    case (code)
      BURST_CODE_4: burstWords = 4'h4;
      BURST_CODE_8: burstWords = 4'h8;
      default: burstWords = 4'h2;
    endcase
  endfunction

endpackage

//--- rtl/lldp_async_fifo.sv
`timescale 1ns/1ps
module lldp_async_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic wrClk, // Filling side clock
  input wire logic wrRst_n, // Filling side reset, active low
  input wire logic wrValid, // Word offered
  output logic wrReady, // Room for a word
  input wire logic [WIDTH-1:0] wrData, // Word in
  input wire logic rdClk, // Draining side clock
  input wire logic rdRst_n, // Draining side reset, active low
  output logic rdValid, // Word available
  input wire logic rdReady, // Drain takes the word
  output logic [WIDTH-1:0] rdData // Word out
);
  localparam int AW = $clog2(DEPTH);

  // Gray full test flips the top two pointer bits, so the index needs at least two bits
  generate
    if (DEPTH < 4 || (DEPTH & (DEPTH - 1)) != 0) begin : gBadDepth
      $error("lldp_async_fifo: DEPTH must be a power of two of at least 4");
    end
  endgenerate

  logic [WIDTH-1:0] store [0:DEPTH-1];
  logic [AW:0] wrBin;
  logic [AW:0] wrGray;
  logic [AW:0] rdBin;
  logic [AW:0] rdGray;
  logic [AW:0] rdGrayMeta;
  logic [AW:0] rdGraySync;
  logic [AW:0] wrGrayMeta;
  logic [AW:0] wrGraySync;
  logic [AW:0] wrBinNext;
  logic [AW:0] rdBinNext;

  assign wrBinNext = wrBin + 1'b1;
  assign rdBinNext = rdBin + 1'b1;
  // Full when write pointer is one lap ahead of the synced read pointer
  assign wrReady = wrGray != {~rdGraySync[AW:AW-1], rdGraySync[AW-2:0]};
  assign rdValid = rdGray != wrGraySync;
  assign rdData = store[rdBin[AW-1:0]];

  // Storage written only on the filling clock
  always_ff @(posedge wrClk) begin
    if (wrValid && wrReady) begin
      store[wrBin[AW-1:0]] <= wrData;
    end
  end

  // Write pointer, binary and Gray kept together
  always_ff @(posedge wrClk or negedge wrRst_n) begin
    if (!wrRst_n) begin
      wrBin <= '0;
      wrGray <= '0;
    end else if (wrValid && wrReady) begin
      wrBin <= wrBinNext;
      wrGray <= wrBinNext ^ (wrBinNext >> 1);
    end
  end

  // Read pointer
  always_ff @(posedge rdClk or negedge rdRst_n) begin
    if (!rdRst_n) begin
      rdBin <= '0;
      rdGray <= '0;
    end else if (rdValid && rdReady) begin
      rdBin <= rdBinNext;
      rdGray <= rdBinNext ^ (rdBinNext >> 1);
    end
  end

  // Only one Gray bit moves per step, so two flops are enough
  always_ff @(posedge wrClk or negedge wrRst_n) begin
    if (!wrRst_n) begin
      rdGrayMeta <= '0;
      rdGraySync <= '0;
    end else begin
      rdGrayMeta <= rdGray;
      rdGraySync <= rdGrayMeta;
    end
  end

  always_ff @(posedge rdClk or negedge rdRst_n) begin
    if (!rdRst_n) begin
      wrGrayMeta <= '0;
      wrGraySync <= '0;
    end else begin
      wrGrayMeta <= wrGray;
      wrGraySync <= wrGrayMeta;
    end
  end

endmodule // lldp_async_fifo

//--- tb/lldp_port_asserts.sv
`timescale 1ns/1ps
module lldp_port_asserts (
  input wire logic clk, // Core clock
  input wire logic rst_n, // Reset, active low
  input wire logic commandClockTrue, // Command clock
  input wire logic selectN, // Chip select, active low
  input wire logic writeEnableN, // Write enable, active low
  input wire logic refreshN, // Refresh strobe, active low
  input wire logic [lldp_pkg::ADDR_W-1:0] addr, // Word address
  input wire logic dataOutEn, // Data pins driven
  input wire logic readDataClock, // Read data clock
  input wire logic readValid, // Read word present
  input wire logic [1:0] burstCount, // Burst code
  input wire logic cmdDropped, // Refused command
  input wire logic refreshDone // Refresh executed
);
  logic [2:0] upCnt;
  wire logic modeSet = !selectN && !writeEnableN && !refreshN;
  wire logic queued = !selectN && (writeEnableN || refreshN);

  // Link side leaves reset two edges late, so toggling is judged only after that
  always_ff @(posedge commandClockTrue or negedge rst_n) begin
    if (!rst_n) upCnt <= 3'h0;
    else if (upCnt != 3'h4) upCnt <= upCnt + 3'h1;
  end

  // Whole bursts of the programmed length, two or eight words, then a gap
  sequence sRun2;
    readValid [*2] ##1 !readValid;
  endsequence
  sequence sRun8;
    readValid [*8] ##1 !readValid;
  endsequence

  a_rclk_free_toggle: assert property (@(posedge commandClockTrue) disable iff (!rst_n)
    upCnt == 3'h4 |-> readDataClock != $past(readDataClock)) else $error("read clock stalled");
  a_valid_drive_same: assert property (@(posedge commandClockTrue) disable iff (!rst_n)
    readValid == dataOutEn) else $error("valid and drive differ");
  a_word0_clock_high: assert property (@(posedge commandClockTrue) disable iff (!rst_n)
    $rose(readValid) |-> readDataClock) else $error("first word off phase");
  a_burst_two_words: assert property (@(posedge commandClockTrue) disable iff (!rst_n)
    $rose(readValid) && burstCount == 2'h0 |-> sRun2) else $error("burst of two wrong");
  a_burst_eight_words: assert property (@(posedge commandClockTrue) disable iff (!rst_n)
    $rose(readValid) && burstCount == 2'h2 |-> sRun8) else $error("burst of eight wrong");
  a_mode_code_taken: assert property (@(posedge commandClockTrue) disable iff (!rst_n)
    modeSet && addr[1:0] != 2'h3 |=> burstCount == $past(addr[1:0])) else $error("mode not set");
  a_mode_reserved_kept: assert property (@(posedge commandClockTrue) disable iff (!rst_n)
    modeSet && addr[1:0] == 2'h3 |=> $stable(burstCount)) else $error("reserved mode taken");
  a_drop_has_cause: assert property (@(posedge commandClockTrue) disable iff (!rst_n)
    cmdDropped |-> $past(queued)) else $error("drop without command");
  a_refresh_one_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    refreshDone |=> !refreshDone) else $error("refresh pulse too long");
endmodule // lldp_port_asserts

bind lldp_port lldp_port_asserts u_chk (.clk, .rst_n, .commandClockTrue, .selectN,
  .writeEnableN, .refreshN, .addr, .dataOutEn, .readDataClock, .readValid, .burstCount,
  .cmdDropped, .refreshDone);

//--- tb/lldp_ctrl_model.sv
`timescale 1ns/1ps
// Memory controller on the far side; pins move on command clock edges, except the timed end of a glitch
module lldp_ctrl_model (
  input wire logic cc, // Command clock
  output logic [2:0] code, // Select, write enable, refresh
  output logic [lldp_pkg::BANK_W-1:0] bankSel, // Bank address
  output logic [lldp_pkg::ADDR_W-1:0] addrSel, // Word address
  output logic [lldp_pkg::DATA_W-1:0] dataDrv // Data pins
);
  logic busy;
  initial begin
    code = 3'h7;
    bankSel = '0;
    addrSel = '0;
    dataDrv = '0;
    busy = 1'b0;
  end

  // Idle data keeps changing so stale words never pass as written ones
  always @(posedge cc) if (!busy) dataDrv <= ~dataDrv;

  // Command for the next rising edge; a refresh carries only a bank
  task automatic issue(input logic [2:0] c, input logic [2:0] b, input logic [5:0] a);
    @(posedge cc);
    code <= c;
    bankSel <= b;
    addrSel <= a;
  endtask

  task automatic nop();
    @(posedge cc);
    code <= 3'h7;
  endtask

  // Bench sets the burst code first and sizes bl to it
  task automatic write(input logic [2:0] b, input logic [5:0] a,
                       input lldp_pkg::lldp_burst_t w, input int bl);
    busy = 1'b1;
    issue(3'h1, b, a);
    @(posedge cc);
    code <= 3'h7;
    dataDrv <= w[0];
    for (int i = 0; i < bl; i += 2) begin
      @(posedge cc);
      dataDrv <= w[i+1];
      @(negedge cc);
      dataDrv <= (i + 2 < bl) ? w[i+2] : ~w[i+1];
    end
    busy = 1'b0;
  endtask

  // Command present only around a falling edge
  task automatic glitch(input logic [2:0] c);
    @(negedge cc);
    code <= c;
    #40;
    code <= 3'h7;
  endtask
endmodule // lldp_ctrl_model

//--- tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic clk, rst_n, cc, dataOutEn, readDataClock, readValid, cmdDropped, refreshDone;
  logic [2:0] code;
  logic [lldp_pkg::BANK_W-1:0] bankSel, refreshBank;
  logic [lldp_pkg::ADDR_W-1:0] addrSel;
  logic [lldp_pkg::DATA_W-1:0] dataDrv, dataOut;
  logic [1:0] burstCount;
  logic [7:0] refreshRow;
  logic [8:0] rdQ[$];
  logic [10:0] refQ[$];
  int n_errors = 0;
  int samples_checked = 0;
  int nDrop = 0;

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Link clock unrelated in phase to the core clock
  initial begin
    cc = 1'b0;
    #17;
    forever #62.5 cc = ~cc;
  end

  lldp_port #(.ROW_W(8)) u_dut (.clk(clk), .rst_n(rst_n), .commandClockTrue(cc),
    .selectN(code[2]), .writeEnableN(code[1]), .refreshN(code[0]), .bank(bankSel),
    .addr(addrSel), .writeDataClock(cc), .dataIn(dataDrv), .dataOut(dataOut),
    .dataOutEn(dataOutEn), .readDataClock(readDataClock), .readValid(readValid),
    .burstCount(burstCount), .cmdDropped(cmdDropped), .refreshDone(refreshDone),
    .refreshBank(refreshBank), .refreshRow(refreshRow));
  lldp_ctrl_model u_ctrl (.cc(cc), .code(code), .bankSel(bankSel), .addrSel(addrSel),
    .dataDrv(dataDrv));

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Read words taken mid-cycle, where they have settled
  always @(negedge cc) if (readValid === 1'b1) begin
    rdQ.push_back(dataOut);
    chk("read clock phase", readDataClock, rdQ.size() % 2);
  end
  always @(posedge cc) if (cmdDropped === 1'b1) nDrop++;
  always @(posedge clk) if (refreshDone === 1'b1) refQ.push_back({refreshBank, refreshRow});

  task automatic waitCc(input int n);
    repeat (n) @(posedge cc);
  endtask

  task automatic waitRd(input int n);
    for (int i = 0; i < 40 && rdQ.size() < n; i++) @(posedge cc);
    waitCc(3);
  endtask

  task automatic test_reset();
    logic r0;
    chk("burst code", burstCount, 16'h0);
    chk("driving", dataOutEn, 16'h0);
    @(negedge cc);
    r0 = readDataClock;
    @(negedge cc);
    chk("read clock", readDataClock, !r0);
    $display("test_reset done");
  endtask

  task automatic test_edge();
    rdQ.delete();
    nDrop = 0;
    u_ctrl.glitch(3'h3);
    waitCc(10);
    chk("falling edge read", rdQ.size(), 16'h0);
    chk("falling edge drop", nDrop, 16'h0);
    $display("test_edge done");
  endtask

  // Each code in turn; neighbour bank written after, addr wraps at 63
  task automatic test_bursts();
    lldp_pkg::lldp_burst_t w, v;
    int bl;
    for (int c = 0; c < 3; c++) begin
      bl = 2 << c;
      u_ctrl.issue(3'h0, 3'h0, 6'(c));
      u_ctrl.nop();
      waitCc(2);
      chk("burst code", burstCount, 16'(c));
      for (int j = 0; j < 8; j++) w[j] = 9'(16 * c + j + 9'h40);
      v = ~w;
      u_ctrl.write(3'(c * 3), 6'h3e, w, bl);
      waitCc(3);
      u_ctrl.write(3'(c * 3 + 1), 6'h3e, v, bl);
      waitCc(3);
      rdQ.delete();
      u_ctrl.issue(3'h3, 3'(c * 3), 6'h3e);
      u_ctrl.nop();
      waitRd(bl);
      chk("burst words", rdQ.size(), 16'(bl));
      for (int j = 0; j < bl; j++) chk("read word", rdQ[j], w[j]);
    end
    u_ctrl.issue(3'h0, 3'h0, 6'h03);
    u_ctrl.nop();
    waitCc(2);
    chk("reserved code", burstCount, 16'h2);
    $display("test_bursts done");
  endtask

  // Rows count per bank; a refresh one edge too soon is refused
  task automatic test_refresh();
    refQ.delete();
    nDrop = 0;
    u_ctrl.issue(3'h2, 3'h3, 6'h15);
    u_ctrl.nop();
    u_ctrl.issue(3'h2, 3'h3, 6'h2a);
    u_ctrl.nop();
    u_ctrl.issue(3'h2, 3'h5, 6'h15);
    u_ctrl.nop();
    u_ctrl.issue(3'h2, 3'h1, 6'h0);
    u_ctrl.issue(3'h2, 3'h2, 6'h0);
    u_ctrl.nop();
    waitCc(8);
    chk("refresh count", refQ.size(), 16'h4);
    chk("refresh 0", refQ[0], {3'h3, 8'h0});
    chk("refresh 1", refQ[1], {3'h3, 8'h1});
    chk("refresh 2", refQ[2], {3'h5, 8'h0});
    chk("refresh 3", refQ[3], {3'h1, 8'h0});
    chk("dropped", nDrop, 16'h1);
    $display("test_refresh done");
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Link side resets at once; its release waits two link edges
  initial begin
    rst_n = 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    waitCc(4);
    test_reset();
    test_edge();
    test_bursts();
    test_refresh();
    end_sim();
  end

  // Tests need about 18 us; over ten times that means a hang
  initial begin
    #250000;
    n_errors++;
    end_sim();
  end
endmodule // testbench
